/* File: tb/rhcp_top_monitor.sv */
// port checker for receive channel provisioning
`timescale 1ns/1ps
`default_nettype none
module rhcp_top_monitor (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_reg_rd,
  input wire logic [3:0] i_reg_be,
  input wire logic [31:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire rhcp_pkg::rhcp_line_t i_line,
  input wire rhcp_pkg::rhcp_hdlc_bit_t o_hdlc_bit,
  input wire rhcp_pkg::rhcp_hdlc_byte_t i_hdlc_byte,
  input wire rhcp_pkg::rhcp_store_t o_store,
  input wire rhcp_pkg::rhcp_desc_t o_desc,
  input wire logic i_dma_ack,
  input wire logic o_dma_req,
  input wire logic [rhcp_pkg::CHAN_W-1:0] o_dma_chan,
  input wire logic [rhcp_pkg::BURST_W:0] o_dma_burst_blocks,
  input wire logic [rhcp_pkg::BURST_W+4:0] o_dma_burst_bytes
);
  // ****************************
  // properties
  // ****************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  chk_read_answer: assert property (
    i_reg_rd && (i_reg_be != 4'h0) |=> o_reg_rvalid) else $error("read unanswered");
  chk_rdata_quiet: assert property (
    !o_reg_rvalid |-> o_reg_rdata == 32'h0) else $error("rdata not idle");
  chk_bit_source: assert property (
    o_hdlc_bit.valid |-> $past(i_line.valid) && o_hdlc_bit.chan == $past(i_line.chan))
    else $error("bit without line bit");
  chk_crc_ignored: assert property (
    o_hdlc_bit.valid && !o_hdlc_bit.flag_delineation_enable |-> o_hdlc_bit.crc == 2'h0 && !o_hdlc_bit.fcs_discard)
    else $error("crc set without delineation");
  chk_discard_crc: assert property (
    o_hdlc_bit.fcs_discard |-> o_hdlc_bit.crc != 2'h0) else $error("discard with no crc");
  chk_store_source: assert property (
    o_store.valid |-> $past(i_hdlc_byte.valid) && $past(i_hdlc_byte.data) == o_store.data)
    else $error("store without byte");
  chk_pad_sop: assert property (
    o_store.valid && !o_store.sop |-> o_store.pad == 2'h0) else $error("pad off start");
  chk_desc_eop: assert property (
    o_desc.valid |-> $past(i_hdlc_byte.valid && i_hdlc_byte.eop)) else $error("desc no eop");
  chk_burst_size: assert property (
    o_dma_req |-> o_dma_burst_bytes == {o_dma_burst_blocks, 4'h0} && o_dma_burst_blocks != 5'h0)
    else $error("burst size");
  chk_req_hold: assert property (
    o_dma_req && !i_dma_ack |=> o_dma_req && $stable(o_dma_chan) && $stable(o_dma_burst_blocks))
    else $error("request dropped");
  cover property (o_dma_req && i_dma_ack);
  cover property (o_store.valid && o_store.pad != 2'h0);
  cover property (o_desc.valid);
  cover property (o_hdlc_bit.valid && o_hdlc_bit.fcs_discard);
endmodule : rhcp_top_monitor
bind rhcp_top rhcp_top_monitor i_rhcp_top_monitor (.i_clock, .i_rst_n, .i_reg_rd, .i_reg_be,
  .o_reg_rdata, .o_reg_rvalid, .i_line, .o_hdlc_bit, .i_hdlc_byte, .o_store, .o_desc,
  .i_dma_ack, .o_dma_req, .o_dma_chan, .o_dma_burst_blocks, .o_dma_burst_bytes);
`default_nettype wire

/* File: tb/rhcp_top_tb.sv */
// self-checking bench for receive channel provisioning
`timescale 1ns/1ps
`default_nettype none
`define CHK(e, g, n) begin ev = (e); n_compared++; if ((g) !== ev) begin fail_count++; \
  $display("Error %s exp %h got %h", n, ev, g); end end
module rhcp_top_tb;
  logic i_clock = 0, i_rst_n = 0, i_reg_wr = 0, i_reg_rd = 0, i_dma_ack = 0;
  logic [11:0] i_reg_addr = '0;
  logic [3:0] i_reg_be = '0;
  logic [31:0] i_reg_wdata = '0, o_reg_rdata, ev, got, seed = 32'h7949;
  rhcp_pkg::rhcp_line_t i_line = '0;
  rhcp_pkg::rhcp_hdlc_byte_t i_hdlc_byte = '0;
  rhcp_pkg::rhcp_fifo_status_t i_fifo_status = '0;
  rhcp_pkg::rhcp_hdlc_bit_t o_hdlc_bit;
  rhcp_pkg::rhcp_store_t o_store;
  rhcp_pkg::rhcp_desc_t o_desc;
  logic o_reg_rvalid, o_dma_req, o_dma_priority;
  logic [7:0] o_dma_chan;
  logic [4:0] o_dma_burst_blocks;
  logic [8:0] o_dma_burst_bytes;
  logic [31:0] rq[$], bq[$], sq[$], eq[$], mq[$];
  int fail_count = 0, n_compared = 0, cyc = 0, n3 = 0;
  rhcp_top i_rhcp_top (.i_clock, .i_rst_n, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_be,
    .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_line, .o_hdlc_bit, .i_hdlc_byte, .o_store,
    .o_desc, .i_fifo_status, .i_dma_ack, .o_dma_req, .o_dma_chan, .o_dma_priority,
    .o_dma_burst_blocks, .o_dma_burst_bytes);
  always #5 i_clock = ~i_clock;
  // ****************************
  // drivers and watcher
  // ****************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  task automatic give_verdict();
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_be = 4'hF;
    i_reg_wr = 1'b1;
    @(posedge i_clock);
    // strobe stays up until the next access takes over
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input bit t);
    if (t) rq.push_back(e);
    i_reg_wr = 1'b0;
    i_reg_addr = a;
    i_reg_be = 4'hF;
    i_reg_rd = 1'b1;
    @(posedge i_clock);
    #1 i_reg_rd = 1'b0;
    got = o_reg_rdata;
    @(posedge i_clock);
    #1;
  endtask : rd
  task automatic trig(input logic [11:0] a, input logic [31:0] d);
    wr(a, d);
    for (int k = 0; k < 20 && (k == 0 || got[15]); k++) begin
      rd(a, 32'h0, 0);
      if (k == 0) `CHK(32'h1, got[15], "busy")
    end
    rd(a, d, 1);
  endtask : trig
  task automatic channel_enable_flag(input logic [7:0] ch, input logic [31:0] d1, d2);
    wr(12'h204, d1);
    wr(12'h208, d2);
    trig(12'h200, {24'h0, ch});
  endtask : channel_enable_flag
  task automatic byt(input logic [7:0] ch, d, input logic s, e, c, st);
    i_hdlc_byte = {1'b1, ch, d, s, e, c};
    if (st) sq.push_back({1'b1, ch, d, s, (s && ch == 8'h03) ? 2'h2 : 2'h0});
    @(posedge i_clock);
    #1;
  endtask : byt
  task automatic stat(input logic [7:0] ch, input logic [11:0] dep, input logic e);
    i_fifo_status = {1'b1, ch, dep, e};
    @(posedge i_clock);
    #1;
  endtask : stat
  always @(posedge i_clock) i_dma_ack <= #1 o_dma_req && !i_dma_ack;
  always @(posedge i_clock) begin
    if (o_reg_rvalid && rq.size() > 0)
      `CHK(rq.pop_front(), o_reg_rdata, "rdata")
    if (o_hdlc_bit.valid)
      `CHK(bq.size() ? bq.pop_front() : 'x, 32'(o_hdlc_bit), "bit")
    if (o_store.valid)
      `CHK(sq.size() ? sq.pop_front() : 'x, 32'(o_store), "store")
    if (o_desc.valid) `CHK(eq.size() ? eq.pop_front() : 'x, 32'(o_desc), "desc")
    if (o_dma_req && i_dma_ack) `CHK(mq.size() ? mq.pop_front() : 'x, 32'({o_dma_chan,
      o_dma_priority, o_dma_burst_blocks, o_dma_burst_bytes}), "dma")
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge i_clock);
    #1 i_rst_n = 1'b1;
    seed = xs(seed);
    wr(12'h208, seed & 32'hEF0F);
    rd(12'h208, seed & 32'hEF0F, 1);
    // bursts well under allocation, one priority channel
    channel_enable_flag(8'h02, 32'h8000, 32'h0);
    channel_enable_flag(8'h03, 32'hE000 | (seed & 32'h7FF), 32'hA602);
    channel_enable_flag(8'h04, 32'hC000, 32'h4805);
    wr(12'h208, 32'h0);
    trig(12'h200, 32'h4003);
    rd(12'h208, 32'hA602, 1);
    rd(12'h204, 32'hE000, 1);
    wr(12'h214, (seed >> 16) & 32'h7FF);
    trig(12'h210, 32'h0123);
    wr(12'h214, 32'h0);
    trig(12'h210, 32'h4123);
    rd(12'h214, (seed >> 16) & 32'h7FF, 1);
    rd(12'h220, 32'h0, 1);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      i_line = {1'b1, seed[0], 8'(3 + i % 3)};
      if (i % 3 == 0 && n3++ % 8 != 7) bq.push_back({1'b1, ~seed[0], 8'h03, 1'b1, 2'h1, 1'b1});
      if (i % 3 == 1) bq.push_back({1'b1, seed[0], 8'h04, 4'h0});
      @(posedge i_clock);
      #1;
    end
    i_line = '0;
    eq.push_back({1'b1, 8'h03, 16'h0004});
    eq.push_back({1'b1, 8'h04, 16'h0003});
    byt(8'h03, 8'hA1, 1, 0, 0, 1);
    byt(8'h03, 8'hB2, 0, 0, 0, 1);
    byt(8'h03, 8'hC3, 0, 0, 1, 0);
    byt(8'h03, 8'hD4, 0, 1, 1, 0);
    byt(8'h04, 8'h5E, 1, 0, 0, 1);
    byt(8'h04, 8'h6F, 0, 0, 1, 1);
    byt(8'h04, 8'h70, 0, 1, 1, 1);
    i_hdlc_byte = '0;
    mq.push_back({8'h03, 1'b0, 5'h03, 9'h030});
    mq.push_back({8'h04, 1'b1, 5'h06, 9'h060});
    mq.push_back({8'h02, 1'b0, 5'h01, 9'h010});
    stat(8'h03, 12'h003, 0);
    stat(8'h02, 12'h000, 1);
    stat(8'h04, 12'h006, 0);
    i_fifo_status = '0;
    repeat (30) @(posedge i_clock);
    `CHK(32'h0, rq.size() + bq.size() + sq.size() + eq.size() + mq.size(), "left")
    give_verdict();
  end
endmodule : rhcp_top_tb
`default_nettype wire

/* File: verilog/rhcp_bit_cond.sv */
// per-channel line bit conditioning: gating, inversion and octet lsb drop
`timescale 1ns/1ps
`default_nettype none
module rhcp_bit_cond #(
  parameter int CHANNELS = 256
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire rhcp_pkg::rhcp_line_t i_line,
  input wire rhcp_pkg::rhcp_channel_enable_flag_t i_cfg,
  output rhcp_pkg::rhcp_hdlc_bit_t o_bit
);
  logic [2:0] bit_pos [CHANNELS];
  logic take;
  logic drop;

  assign take = i_line.valid && (32'(i_line.chan) < CHANNELS) && i_cfg.enable;
  assign drop = i_cfg.drop_lsb && (bit_pos[i_line.chan] == rhcp_pkg::OCTET_LAST_BIT);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        bit_pos[i] <= 3'h0;
      end
    end else if (take) begin
      bit_pos[i_line.chan] <= bit_pos[i_line.chan] + 3'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bit <= '0;
    end else begin
      o_bit.valid <= take && !drop;
      o_bit.data <= i_line.data ^ i_cfg.invert;
      o_bit.chan <= i_line.chan;
      o_bit.flag_delineation_enable <= i_cfg.flag_delineation_enable;
      o_bit.crc <= rhcp_pkg::eff_crc(i_cfg);
      o_bit.fcs_discard <= rhcp_pkg::eff_fcs_discard(i_cfg);
    end
  end
endmodule : rhcp_bit_cond
`default_nettype wire

/* File: verilog/rhcp_fifo_gate.sv */
// per-channel fifo write gating with pad accounting and byte counts
`timescale 1ns/1ps
`default_nettype none
module rhcp_fifo_gate #(
  parameter int CHANNELS = 256
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire rhcp_pkg::rhcp_hdlc_byte_t i_byte,
  input wire rhcp_pkg::rhcp_channel_enable_flag_t i_cfg,
  output rhcp_pkg::rhcp_store_t o_store,
  output rhcp_pkg::rhcp_desc_t o_desc
);
  logic [rhcp_pkg::COUNT_W-1:0] count [CHANNELS];
  logic [rhcp_pkg::COUNT_W-1:0] next_count;
  logic take;
  logic keep;

  assign take = i_byte.valid && (32'(i_byte.chan) < CHANNELS) && i_cfg.enable;
  assign keep = !(i_byte.is_crc && rhcp_pkg::eff_fcs_discard(i_cfg));

  always_comb begin
    next_count = i_byte.sop ? rhcp_pkg::COUNT_W'(i_cfg.pad) : count[i_byte.chan];
    next_count = next_count + rhcp_pkg::COUNT_W'(keep);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        count[i] <= '0;
      end
    end else if (take) begin
      count[i_byte.chan] <= next_count;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_store <= '0;
      o_desc <= '0;
    end else begin
      o_store.valid <= take && keep;
      o_store.chan <= i_byte.chan;
      o_store.data <= i_byte.data;
      o_store.sop <= i_byte.sop;
      o_store.pad <= i_byte.sop ? i_cfg.pad : '0;
      o_desc.valid <= take && i_byte.eop;
      o_desc.chan <= i_byte.chan;
      o_desc.bytes_in_buffer <= next_count;
    end
  end
endmodule : rhcp_fifo_gate
`default_nettype wire

/* File: verilog/rhcp_pkg.sv */
// constants, field layouts and carrier types for receive channel provisioning
`default_nettype none
package rhcp_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [11:0] OFF_CHAN_SEL = 12'h200;
  localparam logic [11:0] OFF_CHAN_DATA1 = 12'h204;
  localparam logic [11:0] OFF_CHAN_DATA2 = 12'h208;
  localparam logic [11:0] OFF_BLK_SEL = 12'h210;
  localparam logic [11:0] OFF_BLK_DATA = 12'h214;
  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_BUSY = 15;
  localparam int BIT_RWB = 14;
  localparam int BIT_ENABLE = 15;
  localparam int BIT_FCS_DISCARD = 14;
  localparam int BIT_FLAG_DELINEATION_ENABLE = 13;
  localparam int BIT_TAVAIL = 12;
  localparam int BIT_DROP = 15;
  localparam int BIT_PRIO = 14;
  localparam int BIT_INVERT = 13;
  localparam int LSB_CRC = 10;
  localparam int LSB_PAD = 8;
  localparam int LSB_BURST = 0;
  localparam int CHAN_W = 8;
  localparam int PTR_W = 11;
  localparam int CRC_W = 2;
  localparam int PAD_W = 2;
  localparam int BURST_W = 4;
  localparam int COUNT_W = 16;
  // ****************************************
  // encodings and sizes
  // ****************************************
  localparam logic [CRC_W-1:0] CRC_NONE = 2'h0;
  localparam logic [CRC_W-1:0] CRC_CCITT = 2'h1;
  localparam logic [CRC_W-1:0] CRC_32 = 2'h2;
  localparam logic [2:0] OCTET_LAST_BIT = 3'h7;
  localparam logic [3:0] BLOCK_BYTES_LOG2 = 4'h4;
  localparam logic [31:0] RDATA_NONE = 32'h00000000;

  typedef struct packed {
    logic enable;
    logic fcs_discard;
    logic flag_delineation_enable;
    logic [PTR_W-1:0] fptr;
    logic drop_lsb;
    logic priority_hi;
    logic invert;
    logic [CRC_W-1:0] crc;
    logic [PAD_W-1:0] pad;
    logic [BURST_W-1:0] burst;
  } rhcp_channel_enable_flag_t;

  typedef struct packed {
    logic valid;
    logic data;
    logic [CHAN_W-1:0] chan;
  } rhcp_line_t;

  typedef struct packed {
    logic valid;
    logic data;
    logic [CHAN_W-1:0] chan;
    logic flag_delineation_enable;
    logic [CRC_W-1:0] crc;
    logic fcs_discard;
  } rhcp_hdlc_bit_t;

  typedef struct packed {
    logic valid;
    logic [CHAN_W-1:0] chan;
    logic [7:0] data;
    logic sop;
    logic eop;
    logic is_crc;
  } rhcp_hdlc_byte_t;

  typedef struct packed {
    logic valid;
    logic [CHAN_W-1:0] chan;
    logic [7:0] data;
    logic sop;
    logic [PAD_W-1:0] pad;
  } rhcp_store_t;

  typedef struct packed {
    logic valid;
    logic [CHAN_W-1:0] chan;
    logic [COUNT_W-1:0] bytes_in_buffer;
  } rhcp_desc_t;

  typedef struct packed {
    logic valid;
    logic [CHAN_W-1:0] chan;
    logic [PTR_W:0] depth_blocks;
    logic eop_present;
  } rhcp_fifo_status_t;

  // check type in force: none when delineation is off
  function automatic logic [CRC_W-1:0] eff_crc(input rhcp_channel_enable_flag_t p);
    eff_crc = p.flag_delineation_enable ? p.crc : CRC_NONE;
  endfunction : eff_crc

  // fcs discard only with delineation on and a check selected
  function automatic logic eff_fcs_discard(input rhcp_channel_enable_flag_t p);
    eff_fcs_discard = p.flag_delineation_enable && p.fcs_discard && (p.crc != CRC_NONE);
  endfunction : eff_fcs_discard
endpackage : rhcp_pkg
`default_nettype wire

/* File: verilog/rhcp_top.sv */
// receive hdlc channel provisioning: registers, provision and block ram, dma request
//
// Summary of operation
// - With discard set and a crc type chosen, received crc bytes are not stored.
// - Packet byte count reflects whether crc bytes were stored or omitted.
// - Discard setting is ignored while flag delineation is off.
// - Enabled channels are processed; disabled channels have all data ignored.
// - Staged fields other than fptr read back as written until an indirect read replaces them; fptr is not readable.
// - Request dma when fifo depth reaches threshold or a packet end is held.
// - Threshold and burst equal the transfer field plus one, in 16-byte blocks.
// - Pad field value gives the invalid bytes placed before each stored packet.
// - Crc type: 00 none, 01 ccitt, 10 crc-32, 11 reserved.
// - Crc type is ignored while flag delineation is off.
// - Inversion set means the incoming channel bits are inverted first.
// - Priority channels are served by dma ahead of normal ones.
// - Seven-bit mode drops the last received bit of every octet.
// - Writing block select starts a block pointer access at the given block.
// - Block read-not-write zero writes from block data; one reads into it.
// - Busy rises on trigger and clears on completion; software polls it.
// - Channel read-not-write zero writes the ram; one reads into data registers.
// - Delineation off means no flags, no de-stuffing and no crc check.
`timescale 1ns/1ps
`default_nettype none
module rhcp_top #(
  parameter int CHANNELS = 256,
  parameter int BLOCKS = 2048,
  parameter int ACCESS_CYCLES = 2
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [11:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [3:0] i_reg_be,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire rhcp_pkg::rhcp_line_t i_line,
  output rhcp_pkg::rhcp_hdlc_bit_t o_hdlc_bit,
  input wire rhcp_pkg::rhcp_hdlc_byte_t i_hdlc_byte,
  output rhcp_pkg::rhcp_store_t o_store,
  output rhcp_pkg::rhcp_desc_t o_desc,
  input wire rhcp_pkg::rhcp_fifo_status_t i_fifo_status,
  input wire logic i_dma_ack,
  output logic o_dma_req,
  output logic [rhcp_pkg::CHAN_W-1:0] o_dma_chan,
  output logic o_dma_priority,
  output logic [rhcp_pkg::BURST_W:0] o_dma_burst_blocks,
  output logic [rhcp_pkg::BURST_W+4:0] o_dma_burst_bytes
);
  // ****************************************
  // elaboration checks
  // ****************************************
  if (CHANNELS < 1 || CHANNELS > 256) begin : g_bad_channels
    $error("CHANNELS must lie in 1..256");
  end
  if (BLOCKS < 1 || BLOCKS > 2048) begin : g_bad_blocks
    $error("BLOCKS must lie in 1..2048");
  end
  if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 255) begin : g_bad_access
    $error("ACCESS_CYCLES must lie in 1..255");
  end

  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_CHAN,
    ENG_BLK
  } rhcp_eng_t;

  localparam logic [7:0] ACCESS_LAST = 8'(ACCESS_CYCLES - 1);

  // ****************************************
  // storage
  // ****************************************
  rhcp_pkg::rhcp_channel_enable_flag_t channel_enable_flag_ram [CHANNELS];
  logic [rhcp_pkg::PTR_W-1:0] block_ram [BLOCKS];
  rhcp_pkg::rhcp_channel_enable_flag_t staged;
  logic tavail;
  logic [rhcp_pkg::CHAN_W-1:0] chan_sel;
  logic chan_rwb;
  logic [rhcp_pkg::PTR_W-1:0] blk_sel;
  logic blk_rwb;
  logic [rhcp_pkg::PTR_W-1:0] blk_data;
  rhcp_eng_t eng_state;
  logic [7:0] eng_count;
  logic [CHANNELS-1:0] needs_xfer;
  logic [CHANNELS-1:0] prio_vec;

  logic wr_hit;
  logic eng_done;
  logic chan_ok;
  logic blk_ok;
  logic [31:0] next_rdata;
  rhcp_pkg::rhcp_channel_enable_flag_t line_cfg;
  rhcp_pkg::rhcp_channel_enable_flag_t byte_cfg;
  rhcp_pkg::rhcp_channel_enable_flag_t stat_cfg;
  logic stat_need;
  logic [rhcp_pkg::CHAN_W:0] pick_hi;
  logic [rhcp_pkg::CHAN_W:0] pick_lo;

  // no access when every byte enable is off; words are written whole
  assign wr_hit = i_reg_wr && (i_reg_be != 4'h0);
  assign eng_done = (eng_state != ENG_IDLE) && (eng_count == ACCESS_LAST);
  assign chan_ok = 32'(chan_sel) < CHANNELS;
  assign blk_ok = 32'(blk_sel) < BLOCKS;

  // ****************************************
  // indirect access engine
  // ****************************************
  // busy until done
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      eng_state <= ENG_IDLE;
      eng_count <= 8'h00;
    end else begin
      case (eng_state)
        ENG_IDLE: begin
          eng_count <= 8'h00;
          if (wr_hit && i_reg_addr == rhcp_pkg::OFF_CHAN_SEL) begin
            eng_state <= ENG_CHAN;
          end else if (wr_hit && i_reg_addr == rhcp_pkg::OFF_BLK_SEL) begin
            eng_state <= ENG_BLK;
          end
        end
        ENG_CHAN, ENG_BLK: begin
          eng_count <= eng_count + 8'h01;
          if (eng_done) begin
            eng_state <= ENG_IDLE;
          end
        end
        default: begin
          eng_state <= ENG_IDLE;
        end
      endcase
    end
  end

  // select registers take a write only while the engine is idle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chan_sel <= '0;
      chan_rwb <= 1'b0;
      blk_sel <= '0;
      blk_rwb <= 1'b0;
    end else if (wr_hit && eng_state == ENG_IDLE) begin
      if (i_reg_addr == rhcp_pkg::OFF_CHAN_SEL) begin
        chan_sel <= i_reg_wdata[rhcp_pkg::CHAN_W-1:0];
        chan_rwb <= i_reg_wdata[rhcp_pkg::BIT_RWB];
      end
      if (i_reg_addr == rhcp_pkg::OFF_BLK_SEL) begin
        blk_sel <= i_reg_wdata[rhcp_pkg::PTR_W-1:0];
        blk_rwb <= i_reg_wdata[rhcp_pkg::BIT_RWB];
      end
    end
  end

  // ****************************************
  // staged channel fields
  // ****************************************
  // hold written value until read completes
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      staged <= '0;
      tavail <= 1'b0;
    end else if (eng_state == ENG_CHAN && eng_done && chan_rwb) begin
      staged <= chan_ok ? channel_enable_flag_ram[chan_sel] : '0;
      tavail <= chan_ok ? needs_xfer[chan_sel] : 1'b0;
    end else if (wr_hit && i_reg_addr == rhcp_pkg::OFF_CHAN_DATA1) begin
      staged.enable <= i_reg_wdata[rhcp_pkg::BIT_ENABLE];
      staged.fcs_discard <= i_reg_wdata[rhcp_pkg::BIT_FCS_DISCARD];
      staged.flag_delineation_enable <= i_reg_wdata[rhcp_pkg::BIT_FLAG_DELINEATION_ENABLE];
      staged.fptr <= i_reg_wdata[rhcp_pkg::PTR_W-1:0];
    end else if (wr_hit && i_reg_addr == rhcp_pkg::OFF_CHAN_DATA2) begin
      staged.drop_lsb <= i_reg_wdata[rhcp_pkg::BIT_DROP];
      staged.priority_hi <= i_reg_wdata[rhcp_pkg::BIT_PRIO];
      staged.invert <= i_reg_wdata[rhcp_pkg::BIT_INVERT];
      staged.crc <= i_reg_wdata[rhcp_pkg::LSB_CRC +: rhcp_pkg::CRC_W];
      staged.pad <= i_reg_wdata[rhcp_pkg::LSB_PAD +: rhcp_pkg::PAD_W];
      staged.burst <= i_reg_wdata[rhcp_pkg::LSB_BURST +: rhcp_pkg::BURST_W];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        channel_enable_flag_ram[i] <= '0;
      end
    end else if (eng_state == ENG_CHAN && eng_done && !chan_rwb && chan_ok) begin
      channel_enable_flag_ram[chan_sel] <= staged;
    end
  end

  // ****************************************
  // block pointer ram
  // ****************************************
  // block write or read
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < BLOCKS; i++) begin
        block_ram[i] <= '0;
      end
    end else if (eng_state == ENG_BLK && eng_done && !blk_rwb && blk_ok) begin
      block_ram[blk_sel] <= blk_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blk_data <= '0;
    end else if (eng_state == ENG_BLK && eng_done && blk_rwb) begin
      blk_data <= blk_ok ? block_ram[blk_sel] : '0;
    end else if (wr_hit && i_reg_addr == rhcp_pkg::OFF_BLK_DATA) begin
      blk_data <= i_reg_wdata[rhcp_pkg::PTR_W-1:0];
    end
  end

  // ****************************************
  // register read
  // ****************************************
  always_comb begin
    next_rdata = rhcp_pkg::RDATA_NONE;
    case (i_reg_addr)
      rhcp_pkg::OFF_CHAN_SEL: begin
        next_rdata[rhcp_pkg::BIT_BUSY] = (eng_state == ENG_CHAN);
        next_rdata[rhcp_pkg::BIT_RWB] = chan_rwb;
        next_rdata[rhcp_pkg::CHAN_W-1:0] = chan_sel;
      end
      rhcp_pkg::OFF_CHAN_DATA1: begin
        next_rdata[rhcp_pkg::BIT_ENABLE] = staged.enable;
        next_rdata[rhcp_pkg::BIT_FCS_DISCARD] = staged.fcs_discard;
        next_rdata[rhcp_pkg::BIT_FLAG_DELINEATION_ENABLE] = staged.flag_delineation_enable;
        next_rdata[rhcp_pkg::BIT_TAVAIL] = tavail;
      end
      rhcp_pkg::OFF_CHAN_DATA2: begin
        next_rdata[rhcp_pkg::BIT_DROP] = staged.drop_lsb;
        next_rdata[rhcp_pkg::BIT_PRIO] = staged.priority_hi;
        next_rdata[rhcp_pkg::BIT_INVERT] = staged.invert;
        next_rdata[rhcp_pkg::LSB_CRC +: rhcp_pkg::CRC_W] = staged.crc;
        next_rdata[rhcp_pkg::LSB_PAD +: rhcp_pkg::PAD_W] = staged.pad;
        next_rdata[rhcp_pkg::LSB_BURST +: rhcp_pkg::BURST_W] = staged.burst;
      end
      rhcp_pkg::OFF_BLK_SEL: begin
        next_rdata[rhcp_pkg::BIT_BUSY] = (eng_state == ENG_BLK);
        next_rdata[rhcp_pkg::BIT_RWB] = blk_rwb;
        next_rdata[rhcp_pkg::PTR_W-1:0] = blk_sel;
      end
      rhcp_pkg::OFF_BLK_DATA: begin
        next_rdata[rhcp_pkg::PTR_W-1:0] = blk_data;
      end
      default: begin
        next_rdata = rhcp_pkg::RDATA_NONE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= rhcp_pkg::RDATA_NONE;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd && (i_reg_be != 4'h0);
      o_reg_rdata <= (i_reg_rd && (i_reg_be != 4'h0)) ? next_rdata : rhcp_pkg::RDATA_NONE;
    end
  end

  // ****************************************
  // data path
  // ****************************************
  assign line_cfg = (32'(i_line.chan) < CHANNELS) ? channel_enable_flag_ram[i_line.chan] : '0;
  assign byte_cfg = (32'(i_hdlc_byte.chan) < CHANNELS) ? channel_enable_flag_ram[i_hdlc_byte.chan] : '0;

  rhcp_bit_cond #(
    .CHANNELS(CHANNELS)
  ) u_bit_cond (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_line(i_line),
    .i_cfg(line_cfg),
    .o_bit(o_hdlc_bit)
  );

  rhcp_fifo_gate #(
    .CHANNELS(CHANNELS)
  ) u_fifo_gate (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_byte(i_hdlc_byte),
    .i_cfg(byte_cfg),
    .o_store(o_store),
    .o_desc(o_desc)
  );

  // ****************************************
  // dma transfer request
  // ****************************************
  // lowest requesting channel among the masked set; msb flags a find
  function automatic logic [rhcp_pkg::CHAN_W:0] pick(input logic [CHANNELS-1:0] mask);
    logic [rhcp_pkg::CHAN_W:0] found;
    found = '0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (mask[i]) begin
        found = {1'b1, rhcp_pkg::CHAN_W'(i)};
      end
    end
    return found;
  endfunction : pick

  for (genvar g = 0; g < CHANNELS; g++) begin : g_prio
    assign prio_vec[g] = channel_enable_flag_ram[g].priority_hi;
  end

  assign stat_cfg = (32'(i_fifo_status.chan) < CHANNELS) ? channel_enable_flag_ram[i_fifo_status.chan] : '0;
  // threshold is field plus one blocks
  assign stat_need = stat_cfg.enable && (i_fifo_status.eop_present ||
      (i_fifo_status.depth_blocks >= (rhcp_pkg::PTR_W + 1)'(stat_cfg.burst) + 12'h001));
  assign pick_hi = pick(needs_xfer & prio_vec & ~(CHANNELS'(o_dma_req) << o_dma_chan));
  assign pick_lo = pick(needs_xfer & ~(CHANNELS'(o_dma_req) << o_dma_chan));

  // a status update wins over the acknowledge clearing the same channel
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      needs_xfer <= '0;
    end else begin
      if (i_dma_ack && o_dma_req) begin
        needs_xfer[o_dma_chan] <= 1'b0;
      end
      if (i_fifo_status.valid && 32'(i_fifo_status.chan) < CHANNELS) begin
        needs_xfer[i_fifo_status.chan] <= stat_need;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dma_req <= 1'b0;
      o_dma_chan <= '0;
      o_dma_priority <= 1'b0;
      o_dma_burst_blocks <= '0;
      o_dma_burst_bytes <= '0;
    end else if (!o_dma_req || i_dma_ack) begin
      o_dma_req <= pick_lo[rhcp_pkg::CHAN_W];
      o_dma_chan <= pick_hi[rhcp_pkg::CHAN_W] ? pick_hi[rhcp_pkg::CHAN_W-1:0]
                                              : pick_lo[rhcp_pkg::CHAN_W-1:0];
      o_dma_priority <= pick_hi[rhcp_pkg::CHAN_W];
      o_dma_burst_blocks <= (rhcp_pkg::BURST_W + 1)'(channel_enable_flag_ram[pick_hi[rhcp_pkg::CHAN_W] ?
          pick_hi[rhcp_pkg::CHAN_W-1:0] : pick_lo[rhcp_pkg::CHAN_W-1:0]].burst) + 5'h01;
      o_dma_burst_bytes <= (rhcp_pkg::BURST_W + 5)'((rhcp_pkg::BURST_W + 5)'(channel_enable_flag_ram[
          pick_hi[rhcp_pkg::CHAN_W] ? pick_hi[rhcp_pkg::CHAN_W-1:0]
          : pick_lo[rhcp_pkg::CHAN_W-1:0]].burst) + 9'h001) << rhcp_pkg::BLOCK_BYTES_LOG2;
    end
  end
endmodule : rhcp_top
`default_nettype wire
